// ### hdl/fmec_pkg.sv
package fmec_pkg;

  // ---------------------------------------------------------------
  // counter and feedback word layout
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W          = 25;
  localparam int unsigned FB_W           = 32;
  localparam logic [3:0]  FB_WORD_OFFSET = 4'h0;
  localparam int unsigned GATE_BIT       = 25;
  localparam int unsigned DIR_BIT        = 26;
  localparam int unsigned AUX_BIT        = 27;
  localparam int unsigned GRP_BIT        = 28;
  localparam int unsigned PARA_BIT       = 29;
  localparam int unsigned TIC_BIT        = 30;
  localparam int unsigned LIFE_BIT       = 31;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [24:0] CNT_RST = 25'h000_0000;
  localparam logic [31:0] FB_RST  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // auxiliary input function select
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FMEC_AUX_OFF   = 3'h0,
    FMEC_AUX_INPUT = 3'h1,
    FMEC_AUX_GATE  = 3'h2,
    FMEC_AUX_SYNC  = 3'h3,
    FMEC_AUX_ZENA  = 3'h4
  } fmec_di_fn_t;

  // load value range is -16777216..+16777215: 25-bit two's complement
  function automatic logic fmec_fn_legal(input logic [2:0] fn);
    fmec_fn_legal = (fn <= 3'h4);
  endfunction : fmec_fn_legal

endpackage : fmec_pkg

// ### hdl/fmec_edge.sv
`timescale 1ns/1ps
// registered edge detector for one synchronous input
module fmec_edge (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sig,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic prev_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_sig;
    end
  end

  assign o_level = i_sig;
  assign o_rise  = i_sig & ~prev_q;
  assign o_fall  = ~i_sig & prev_q;

endmodule : fmec_edge

// ### hdl/fmec_top.sv
`timescale 1ns/1ps
module fmec_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cnt_up,
  input  wire logic        i_cnt_down,
  input  wire logic        i_zero_mark,
  input  wire logic        i_aux_input_pin,
  input  wire logic        i_param_load,
  input  wire logic [2:0]  i_aux_input_function_select,
  input  wire logic        i_gate_invert,
  input  wire logic [24:0] i_load_value,
  input  wire logic        i_iso_configured,
  input  wire logic        i_iso_locked,
  input  wire logic        i_supply_short,
  input  wire logic        i_signal_fault,
  input  wire logic        i_latch_instant,
  output logic [31:0]      o_fast_feedback_word,
  output logic             o_feedback_valid
);

  // ---------------------------------------------------------------
  // parameter set
  // ---------------------------------------------------------------
  logic [2:0]  fn_q;
  logic        inv_q;
  logic [24:0] load_q;
  logic        para_bad_d;
  logic        param_fault_flag_q;

  assign para_bad_d = !fmec_pkg::fmec_fn_legal(i_aux_input_function_select)
                    || (i_gate_invert
                        && i_aux_input_function_select != fmec_pkg::FMEC_AUX_GATE);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fn_q               <= fmec_pkg::FMEC_AUX_OFF;
      inv_q              <= 1'b0;
      load_q             <= fmec_pkg::CNT_RST;
      param_fault_flag_q <= 1'b0;
    end else if (i_param_load) begin
      // a rejected set keeps the block in its previous configuration
      param_fault_flag_q <= para_bad_d;
      if (!para_bad_d) begin
        fn_q   <= i_aux_input_function_select;
        inv_q  <= i_gate_invert;
        load_q <= i_load_value;
      end
    end
  end

  // ---------------------------------------------------------------
  // aux input
  // ---------------------------------------------------------------
  logic aux_rise;
  logic aux_fall;
  logic gate_sig;

  // inversion applies only in gate mode, so it is folded in before edges
  assign gate_sig = i_aux_input_pin ^ (inv_q && fn_q == fmec_pkg::FMEC_AUX_GATE);

  fmec_edge u_edge (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_sig   (gate_sig),
    .o_level (),
    .o_rise  (aux_rise),
    .o_fall  (aux_fall)
  );

  logic input_level_flag;
  assign input_level_flag = i_aux_input_pin;

  // ---------------------------------------------------------------
  // counting gate
  // ---------------------------------------------------------------
  logic hardware_count_gate_q;
  logic gate_open_flag;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hardware_count_gate_q <= 1'b0;
    end else if (i_param_load) begin
      hardware_count_gate_q <= 1'b0;
    end else if (aux_rise) begin
      hardware_count_gate_q <= 1'b1;
    end else if (aux_fall) begin
      hardware_count_gate_q <= 1'b0;
    end
  end

  // a faulty parameter set stops counting until corrected
  assign gate_open_flag = !param_fault_flag_q
                        && ((fn_q != fmec_pkg::FMEC_AUX_GATE) || hardware_count_gate_q);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [24:0] cnt_q;
  logic        count_direction_flag_q;
  logic        step_up;
  logic        step_dn;
  logic        sync_hit;

  // simultaneous up and down pulses cancel, keeping the net position right
  assign step_up = gate_open_flag && i_cnt_up && !i_cnt_down;
  assign step_dn = gate_open_flag && i_cnt_down && !i_cnt_up;

  assign sync_hit = gate_open_flag
                  && ((fn_q == fmec_pkg::FMEC_AUX_SYNC && aux_rise)
                      || (fn_q == fmec_pkg::FMEC_AUX_ZENA && i_aux_input_pin
                          && i_zero_mark));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= fmec_pkg::CNT_RST;
    end else if (i_param_load) begin
      if (!para_bad_d) begin
        cnt_q <= i_load_value;
      end
    end else if (sync_hit) begin
      cnt_q <= load_q;
    end else if (step_up) begin
      cnt_q <= cnt_q + 25'h000_0001;
    end else if (step_dn) begin
      cnt_q <= cnt_q - 25'h000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_direction_flag_q <= 1'b0;
    end else if (step_dn) begin
      count_direction_flag_q <= 1'b1;
    end else if (step_up) begin
      count_direction_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic group_fault_flag;
  logic isochronous_applied_flag;

  assign group_fault_flag         = i_supply_short | i_signal_fault;
  assign isochronous_applied_flag = i_iso_configured & i_iso_locked;

  // ---------------------------------------------------------------
  // feedback word, read-only; no control path exists
  // ---------------------------------------------------------------
  logic [31:0] fb_q;
  logic        alive_toggle_bit_q;
  logic        valid_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fb_q               <= fmec_pkg::FB_RST;
      alive_toggle_bit_q <= 1'b0;
      valid_q            <= 1'b0;
    end else begin
      valid_q <= i_latch_instant;
      if (i_latch_instant) begin
        alive_toggle_bit_q <= ~alive_toggle_bit_q;
        // whole word in one edge so the master never sees mixed bytes
        fb_q <= {~alive_toggle_bit_q, isochronous_applied_flag, param_fault_flag_q,
                 group_fault_flag, input_level_flag, count_direction_flag_q,
                 gate_open_flag, cnt_q};
      end
    end
  end

  assign o_fast_feedback_word = fb_q;
  assign o_feedback_valid     = valid_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_wrap_up: assert property (
    step_up && !sync_hit && !i_param_load && cnt_q == 25'h1FF_FFFF |=> cnt_q == 25'h000_0000)
    else $error("up wrap failed");
  chk_wrap_down: assert property (
    step_dn && !sync_hit && !i_param_load && cnt_q == 25'h000_0000 |=> cnt_q == 25'h1FF_FFFF)
    else $error("down wrap failed");
  chk_gate_hold: assert property (
    !gate_open_flag && !i_param_load |=> cnt_q == $past(cnt_q))
    else $error("count moved while gate closed");
  chk_sync_load: assert property (
    sync_hit && !i_param_load |=> cnt_q == $past(load_q))
    else $error("sync reload missing");
  chk_dir_down: assert property (
    step_dn |=> count_direction_flag_q)
    else $error("direction not set on decrease");
  chk_dir_up: assert property (
    step_up |=> !count_direction_flag_q)
    else $error("direction not cleared on increase");
  chk_life_toggle: assert property (
    i_latch_instant |=> o_fast_feedback_word[31] != $past(o_fast_feedback_word[31]))
    else $error("sign of life not toggled");
  chk_word_count: assert property (
    i_latch_instant |=> o_fast_feedback_word[24:0] == $past(cnt_q))
    else $error("latched count mismatch");
  chk_word_hold: assert property (
    !i_latch_instant |=> $stable(o_fast_feedback_word))
    else $error("feedback word changed outside latch");
  chk_para_invert: assert property (
    i_param_load && i_gate_invert
      && i_aux_input_function_select != fmec_pkg::FMEC_AUX_GATE |=> param_fault_flag_q)
    else $error("invert without gate not flagged");
  chk_gate_open: assert property (
    fn_q == fmec_pkg::FMEC_AUX_GATE && aux_rise && !i_param_load |=> hardware_count_gate_q)
    else $error("gate not opened on rising edge");
  chk_gate_close: assert property (
    fn_q == fmec_pkg::FMEC_AUX_GATE && aux_fall && !i_param_load |=> !hardware_count_gate_q)
    else $error("gate not closed on falling edge");
  chk_gate_resume: assert property (
    fn_q == fmec_pkg::FMEC_AUX_GATE && aux_rise && !i_param_load |=> cnt_q == $past(cnt_q))
    else $error("count changed on gate reopen");
  chk_word_gate: assert property (
    i_latch_instant |=> o_fast_feedback_word[fmec_pkg::GATE_BIT] == $past(gate_open_flag))
    else $error("gate status bit wrong");
  chk_word_dir: assert property (
    i_latch_instant |=> o_fast_feedback_word[fmec_pkg::DIR_BIT] == $past(count_direction_flag_q))
    else $error("direction bit wrong");
  chk_word_level: assert property (
    i_latch_instant |=> o_fast_feedback_word[fmec_pkg::AUX_BIT] == $past(i_aux_input_pin))
    else $error("input level bit wrong");
  chk_word_group: assert property (
    i_latch_instant |=> o_fast_feedback_word[fmec_pkg::GRP_BIT] == ($past(i_supply_short) || $past(i_signal_fault)))
    else $error("group fault bit wrong");
  chk_word_param: assert property (
    i_latch_instant |=> o_fast_feedback_word[fmec_pkg::PARA_BIT] == $past(param_fault_flag_q))
    else $error("parameter fault bit wrong");
  chk_word_iso: assert property (
    i_latch_instant |=> o_fast_feedback_word[fmec_pkg::TIC_BIT] == ($past(i_iso_configured) && $past(i_iso_locked)))
    else $error("isochronous bit wrong");
  chk_valid_pulse: assert property (
    i_latch_instant |=> o_feedback_valid)
    else $error("valid missing after latch");
  chk_valid_idle: assert property (
    !i_latch_instant |=> !o_feedback_valid)
    else $error("valid without latch");
  chk_load_start: assert property (
    i_param_load && !para_bad_d |=> cnt_q == $past(i_load_value))
    else $error("start value not loaded");
  chk_bad_keep: assert property (
    i_param_load && para_bad_d |=> cnt_q == $past(cnt_q) && fn_q == $past(fn_q))
    else $error("rejected set changed state");
  chk_fault_hold: assert property (
    !i_param_load |=> param_fault_flag_q == $past(param_fault_flag_q))
    else $error("parameter fault changed without load");
  chk_fault_stop: assert property (
    param_fault_flag_q |-> !gate_open_flag)
    else $error("counting active with parameter fault");
  chk_zero_sync: assert property (
    fn_q == fmec_pkg::FMEC_AUX_ZENA && gate_open_flag && i_aux_input_pin && i_zero_mark
      && !i_param_load |=> cnt_q == $past(load_q))
    else $error("zero mark reload missing");
  chk_zero_block: assert property (
    fn_q == fmec_pkg::FMEC_AUX_ZENA && !i_aux_input_pin && !i_param_load && !step_up
      && !step_dn |=> cnt_q == $past(cnt_q))
    else $error("zero mark reload without enable");
  chk_count_up: assert property (
    step_up && !sync_hit && !i_param_load |=> cnt_q == $past(cnt_q) + 25'h000_0001)
    else $error("up step wrong");
  chk_count_down: assert property (
    step_dn && !sync_hit && !i_param_load |=> cnt_q == $past(cnt_q) - 25'h000_0001)
    else $error("down step wrong");

  // ---------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------
  cov_wrap_up: cover property (step_up && cnt_q == 25'h1FF_FFFF);
  cov_sync: cover property (sync_hit);
  cov_gate_cycle: cover property (aux_rise ##[1:20] aux_fall);
  cov_para_bad: cover property (param_fault_flag_q);
  cov_inv_gate: cover property (inv_q && fn_q == fmec_pkg::FMEC_AUX_GATE && hardware_count_gate_q);

endmodule : fmec_top

// ### tb/fmec_master.sv
`timescale 1ns/1ps
// bus master: one latch instant per bus cycle, whole word read in one access
module fmec_master #(
  parameter int unsigned PERIOD = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_en,
  input  wire logic [31:0] i_word,
  input  wire logic        i_valid,
  output logic             o_latch,
  output logic [31:0]      o_rx_word
);
  int unsigned cnt_q = 0;
  initial o_latch = 1'b0;
  initial o_rx_word = 32'h0000_0000;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= 0;
      o_latch <= 1'b0;
    end else begin
      cnt_q   <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      o_latch <= i_en && (cnt_q == PERIOD - 1);
    end
  end
  // all four bytes at one edge, so a read never mixes two bus cycles
  always @(posedge i_clk) begin
    if (i_valid) o_rx_word <= i_word;
  end
endmodule : fmec_master

// ### tb/fmec_top_tb.sv
`timescale 1ns/1ps
module fmec_top_tb;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_cnt_up = 1'b0, i_cnt_down = 1'b0;
  logic        i_zero_mark = 1'b0, i_aux_input_pin = 1'b0, i_param_load = 1'b0;
  logic        i_gate_invert = 1'b0, i_iso_configured = 1'b0, i_iso_locked = 1'b0;
  logic        i_supply_short = 1'b0, i_signal_fault = 1'b0, m_en = 1'b0;
  logic [2:0]  i_aux_input_function_select = 3'h0;
  logic [24:0] i_load_value = 25'h000_0000;
  logic        i_latch_instant, o_feedback_valid;
  logic [31:0] o_fast_feedback_word;
  // ---------------------------------------------------------------
  // reference model state
  // ---------------------------------------------------------------
  logic [24:0] m_cnt = 25'h000_0000, m_ld = 25'h000_0000;
  logic [2:0]  m_fn = 3'h0;
  logic        m_hw = 1'b0, m_prev = 1'b0, m_dir = 1'b0, m_flt = 1'b0, m_life = 1'b0;
  logic        m_inv = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000_004C;
  int          fails = 0, n_compared = 0, ph = 0, nld = 0;

  fmec_top i_fmec_top (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cnt_up(i_cnt_up), .i_cnt_down(i_cnt_down),
    .i_zero_mark(i_zero_mark), .i_aux_input_pin(i_aux_input_pin),
    .i_param_load(i_param_load), .i_aux_input_function_select(i_aux_input_function_select),
    .i_gate_invert(i_gate_invert), .i_load_value(i_load_value),
    .i_iso_configured(i_iso_configured), .i_iso_locked(i_iso_locked),
    .i_supply_short(i_supply_short), .i_signal_fault(i_signal_fault),
    .i_latch_instant(i_latch_instant), .o_fast_feedback_word(o_fast_feedback_word),
    .o_feedback_valid(o_feedback_valid)
  );
  fmec_master i_fmec_master (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(m_en), .i_word(o_fast_feedback_word),
    .i_valid(o_feedback_valid), .o_latch(i_latch_instant), .o_rx_word()
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  always #20 i_clk = ~i_clk;
  // ---------------------------------------------------------------
  // model step, compare and drive, all on the rising edge
  // ---------------------------------------------------------------
  // inputs move in fixed slots of the bus cycle so that a one-cycle
  // difference in edge or level sampling cannot change the result
  always @(posedge i_clk) begin : step
    logic        rise, act, lvl;
    logic [31:0] w;
    if (i_rst_n) begin
      lvl  = i_aux_input_pin ^ (m_inv && m_fn == 3'h2);
      rise = lvl & ~m_prev;
      act  = !m_flt && (m_fn != 3'h2 || m_hw);
      if (o_feedback_valid) begin
        w = exp_q.pop_front();
        check({7'h00, o_fast_feedback_word[24:0]}, {7'h00, w[24:0]});
        check({o_fast_feedback_word[31:25], 25'h0}, {w[31:25], 25'h0});
      end
      if (i_latch_instant) begin
        exp_q.push_back({~m_life, i_iso_configured & i_iso_locked, m_flt,
                         i_supply_short | i_signal_fault, i_aux_input_pin, m_dir, act,
                         m_cnt});
        m_life = ~m_life;
      end
      if (i_param_load) begin
        m_en  <= 1'b1;
        m_flt = (i_aux_input_function_select > 3'h4) ||
                (i_gate_invert && i_aux_input_function_select != 3'h2);
        if (!m_flt) begin
          m_fn  = i_aux_input_function_select;
          m_inv = i_gate_invert;
          m_ld  = i_load_value;
          m_cnt = i_load_value;
          m_hw  = 1'b0;
        end
      end else if (act && ((m_fn == 3'h3 && rise) ||
                           (m_fn == 3'h4 && i_aux_input_pin && i_zero_mark))) begin
        m_cnt = m_ld;
      end else if (act && (i_cnt_up ^ i_cnt_down)) begin
        m_cnt = i_cnt_up ? m_cnt + 25'h000_0001 : m_cnt - 25'h000_0001;
        m_dir = i_cnt_down;
      end
      if (!i_param_load && m_fn == 3'h2 && rise) m_hw = 1'b1;
      if (!i_param_load && m_fn == 3'h2 && !lvl && m_prev) m_hw = 1'b0;
      m_prev = lvl;
      ph   = i_latch_instant ? 1 : ph + 1;
      seed = xs(seed);
      i_cnt_up     <= m_en && seed[0] && ph inside {3, 4, 7};
      i_cnt_down   <= m_en && seed[1] && ph inside {3, 4, 7};
      i_zero_mark  <= seed[2] && ph == 5;
      i_param_load <= ph == 6 && (!m_en || seed[6:4] == 3'h0);
      if (ph == 6) begin
        // walk all eight select codes, inversion on every second pass
        i_aux_input_function_select <= nld[2:0];
        i_gate_invert <= nld[3];
        i_load_value  <= seed[13] ? seed[31:7] : (seed[14] ? 25'h1FF_FFFE : 25'h000_0001);
        if (!m_en || seed[6:4] == 3'h0) nld++;
      end
      if (ph == 1) begin
        i_aux_input_pin  <= seed[15] ? ~i_aux_input_pin : i_aux_input_pin;
        i_supply_short   <= seed[16] & seed[17];
        i_signal_fault   <= seed[18] & seed[19];
        i_iso_configured <= seed[20] | seed[22];
        i_iso_locked     <= seed[21];
      end
    end
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (1600) @(posedge i_clk);
    print_verdict();
  end

  // the run needs about 1600 cycles, so this only fires on a hang
  initial begin
    repeat (4000) @(posedge i_clk);
    fails++;
    print_verdict();
  end
endmodule : fmec_top_tb
